/* hw/spc_pkg.sv */
package spc_pkg;
  // Register byte addresses on the AXI4-Lite bus
  localparam logic [3:0] ADDR_CONTROL_1 = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  // spi_control_1 field positions
  localparam int CLOCK_PIN_DISABLE_BIT = 12;
  localparam int SERIAL_OUT_DISABLE_BIT = 11;
  localparam int WORD_WIDTH_SELECT_BIT = 10;
  localparam int SAMPLE_PHASE_BIT = 9;
  localparam int CLOCK_EDGE_BIT = 8;
  localparam int SLAVE_SELECT_ENABLE_BIT = 7;
  localparam int CLOCK_POLARITY_BIT = 6;
  localparam int MASTER_ENABLE_BIT = 5;
  localparam int SECONDARY_PRESCALE_LSB = 2;
  localparam int PRIMARY_PRESCALE_LSB = 0;
  localparam logic [15:0] CONTROL_1_WRITE_MASK = 16'h1fff;
  localparam logic [15:0] CONTROL_1_RESET = 16'h0000;
  // Status register field positions
  localparam int STAT_ENABLE_BIT = 0;
  localparam int STAT_TX_FULL_BIT = 1;
  localparam int STAT_RX_FULL_BIT = 2;
  localparam int STAT_OVERFLOW_BIT = 3;
  // Transfer widths in bits
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spc_pkg

/* hw/spc_shift_engine.sv */
`timescale 1ns/1ns
module spc_shift_engine (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [15:0] tx_word,
  input wire logic wide,
  input wire logic master,
  input wire logic tick,
  input wire logic sck_rise,
  input wire logic sck_fall,
  input wire logic sel_ok,
  input wire logic sdi,
  output logic busy,
  output logic done,
  output logic [15:0] rx_word,
  output logic sdo,
  output logic sck
);
  typedef enum logic {SPC_IDLE, SPC_RUN} spc_eng_state_t;

  spc_eng_state_t state_q, state_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0] cnt_q, cnt_d;
  logic in_q, in_d;
  logic sck_q, sck_d;
  logic done_q, done_d;
  logic rise, fall;
  logic [4:0] nbits;

  always_comb
  begin
    nbits = wide ? spc_pkg::WORD_BITS : spc_pkg::BYTE_BITS;
    rise = master ? (tick && !sck_q) : (sck_rise && sel_ok);
    fall = master ? (tick && sck_q) : (sck_fall && sel_ok);
    state_d = state_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    in_d = in_q;
    sck_d = sck_q;
    done_d = 1'b0;
    case (state_q)
      SPC_IDLE:
      begin
        sck_d = 1'b0;
        if (start)
        begin
          // A byte sits in the upper half so the top bit leaves first
          sh_d = wide ? tx_word : {tx_word[7:0], 8'h00};
          cnt_d = 5'h00;
          state_d = SPC_RUN;
        end
      end
      SPC_RUN:
      begin
        if (rise)
        begin
          in_d = sdi;
          if (master)
            sck_d = 1'b1;
        end
        if (fall)
        begin
          sh_d = {sh_q[14:0], in_q};
          cnt_d = cnt_q + 5'h01;
          if (master)
            sck_d = 1'b0;
          if (cnt_q + 5'h01 == nbits)
          begin
            done_d = 1'b1;
            state_d = SPC_IDLE;
          end
        end
      end
      default: state_d = SPC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= SPC_IDLE;
      sh_q <= 16'h0000;
      cnt_q <= 5'h00;
      in_q <= 1'b0;
      sck_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      in_q <= in_d;
      sck_q <= sck_d;
      done_q <= done_d;
    end
  end

  assign busy = (state_q == SPC_RUN);
  assign done = done_q;
  assign rx_word = wide ? sh_q : {8'h00, sh_q[7:0]};
  assign sdo = sh_q[15];
  assign sck = sck_q;
endmodule : spc_shift_engine

/* hw/spc_top.sv */
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module spc_top (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_data_in_pin,
  input wire logic serial_clock_in_pin,
  input wire logic slave_select_pin,
  output logic serial_data_out_pin,
  output logic serial_data_out_oe,
  output logic serial_clock_out_pin,
  output logic serial_clock_out_oe,
  output logic port_owns_select
);
  // AXI write and read channels
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic wr_fire, rd_fire;
  // Registers
  logic [15:0] control_1_q, control_1_d;
  logic enable_q, enable_d;
  logic [15:0] tx_q, tx_d;
  logic tx_full_q, tx_full_d;
  logic [15:0] rx_q, rx_d;
  logic rx_full_q, rx_full_d;
  logic overflow_q, overflow_d;
  // Pins
  logic [2:0] sync1_q, sync2_q;
  logic sck_prev_q;
  logic sdo_q, sdo_d, sdo_oe_q, sdo_oe_d;
  logic sck_out_q, sck_out_d, sck_oe_q, sck_oe_d;
  logic port_ss_q, port_ss_d;
  // Clock divider
  logic [7:0] div_q, div_d;
  logic tick_q, tick_d;
  logic [7:0] div_limit;
  // Engine
  logic eng_start, eng_busy, eng_done, eng_sdo, eng_sck, sel_ok, is_master;
  logic [15:0] eng_rx;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic addr_known(input logic [3:0] a);
    addr_known = (a == spc_pkg::ADDR_CONTROL_1) || (a == spc_pkg::ADDR_STATUS) ||
                 (a == spc_pkg::ADDR_DATA);
  endfunction : addr_known

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && arready_q;

  always_comb
  begin
    awready_d = awready_q;
    wready_d = wready_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && awready_q)
    begin
      awready_d = 1'b0;
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      wready_d = 1'b0;
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = addr_known(awaddr_q) ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
  end

  always_comb
  begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_fire)
    begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = addr_known(s_axi_araddr) ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        spc_pkg::ADDR_CONTROL_1: rdata_d = {16'h0000, control_1_q};
        spc_pkg::ADDR_STATUS: rdata_d = {28'h0000000, overflow_q, rx_full_q, tx_full_q,
                                         enable_q};
        spc_pkg::ADDR_DATA: rdata_d = {16'h0000, rx_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign is_master = control_1_q[spc_pkg::MASTER_ENABLE_BIT];
  // Select pin is active low; with the enable clear it is never looked at
  assign sel_ok = !control_1_q[spc_pkg::SLAVE_SELECT_ENABLE_BIT] || !sync2_q[2];
  assign eng_start = enable_q && tx_full_q && !eng_busy;

  always_comb
  begin
    control_1_d = control_1_q;
    enable_d = enable_q;
    tx_d = tx_q;
    tx_full_d = tx_full_q;
    rx_d = rx_q;
    rx_full_d = rx_full_q;
    overflow_d = overflow_q;
    if (wr_fire && awaddr_q == spc_pkg::ADDR_CONTROL_1)
      control_1_d = merge16(control_1_q, wdata_q, wstrb_q) & spc_pkg::CONTROL_1_WRITE_MASK;
    if (wr_fire && awaddr_q == spc_pkg::ADDR_STATUS && wstrb_q[0])
    begin
      enable_d = wdata_q[spc_pkg::STAT_ENABLE_BIT];
      if (wdata_q[spc_pkg::STAT_OVERFLOW_BIT])
        overflow_d = 1'b0;
    end
    if (eng_start)
      tx_full_d = 1'b0;
    if (wr_fire && awaddr_q == spc_pkg::ADDR_DATA)
    begin
      tx_d = merge16(tx_q, wdata_q, wstrb_q);
      tx_full_d = 1'b1;
    end
    // Reading the data word frees the receive slot
    if (rd_fire && s_axi_araddr == spc_pkg::ADDR_DATA)
      rx_full_d = 1'b0;
    // A finished transfer wins over a same-cycle clear
    if (eng_done)
    begin
      if (rx_full_q && !(rd_fire && s_axi_araddr == spc_pkg::ADDR_DATA))
        overflow_d = 1'b1;
      else
      begin
        rx_d = eng_rx;
        rx_full_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      control_1_q <= spc_pkg::CONTROL_1_RESET;
      enable_q <= 1'b0;
      tx_q <= 16'h0000;
      tx_full_q <= 1'b0;
      rx_q <= 16'h0000;
      rx_full_q <= 1'b0;
      overflow_q <= 1'b0;
    end
    else
    begin
      control_1_q <= control_1_d;
      enable_q <= enable_d;
      tx_q <= tx_d;
      tx_full_q <= tx_full_d;
      rx_q <= rx_d;
      rx_full_q <= rx_full_d;
      overflow_q <= overflow_d;
    end
  end

  // Divide ratio from the two prescale fields; either field zero gives the fastest rate
  assign div_limit = 8'({control_1_q[4:2], 1'b0} * {control_1_q[1:0], 2'b00} + 4'h1);

  always_comb
  begin
    div_d = div_q + 8'h01;
    tick_d = 1'b0;
    if (!enable_q || !is_master || div_q >= div_limit)
    begin
      div_d = 8'h00;
      tick_d = enable_q && is_master;
    end
  end

  always_comb
  begin
    // Output enables only; the pin wire itself is resolved outside
    sdo_d = eng_sdo;
    sdo_oe_d = enable_q && !control_1_q[spc_pkg::SERIAL_OUT_DISABLE_BIT];
    sck_out_d = eng_sck;
    sck_oe_d = enable_q && is_master && !control_1_q[spc_pkg::CLOCK_PIN_DISABLE_BIT];
    port_ss_d = !(enable_q && control_1_q[spc_pkg::SLAVE_SELECT_ENABLE_BIT]);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Select pin idles high; low reset stages would pose as a select
      sync1_q <= 3'h4;
      sync2_q <= 3'h4;
      sck_prev_q <= 1'b0;
      div_q <= 8'h00;
      tick_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      sck_out_q <= 1'b0;
      sck_oe_q <= 1'b0;
      port_ss_q <= 1'b1;
    end
    else
    begin
      sync1_q <= {slave_select_pin, serial_clock_in_pin, serial_data_in_pin};
      sync2_q <= sync1_q;
      sck_prev_q <= sync2_q[1];
      div_q <= div_d;
      tick_q <= tick_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
      sck_out_q <= sck_out_d;
      sck_oe_q <= sck_oe_d;
      port_ss_q <= port_ss_d;
    end
  end

  spc_shift_engine u_engine (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(eng_start),
    .tx_word(tx_q),
    .wide(control_1_q[spc_pkg::WORD_WIDTH_SELECT_BIT]),
    .master(is_master),
    .tick(tick_q),
    .sck_rise(sync2_q[1] && !sck_prev_q),
    .sck_fall(!sync2_q[1] && sck_prev_q),
    .sel_ok(sel_ok),
    .sdi(sync2_q[0]),
    .busy(eng_busy),
    .done(eng_done),
    .rx_word(eng_rx),
    .sdo(eng_sdo),
    .sck(eng_sck)
  );

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign serial_data_out_pin = sdo_q;
  assign serial_data_out_oe = sdo_oe_q;
  assign serial_clock_out_pin = sck_out_q;
  assign serial_clock_out_oe = sck_oe_q;
  assign port_owns_select = port_ss_q;

  logic [4:0] fall_cnt_q;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      fall_cnt_q <= 5'h00;
    else if (eng_start)
      fall_cnt_q <= 5'h00;
    else if (eng_busy && !eng_sck && sck_out_d == 1'b0 && $fell(eng_sck))
      fall_cnt_q <= fall_cnt_q + 5'h01;
  end

  AST_SDO_DISABLED: assert property (@(posedge ref_clk) disable iff (!rst_b)
    control_1_q[spc_pkg::SERIAL_OUT_DISABLE_BIT] |=> !serial_data_out_oe)
    else $error("data out driven while disabled");
  AST_SDO_DRIVEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (enable_q && !control_1_q[spc_pkg::SERIAL_OUT_DISABLE_BIT]) |=> serial_data_out_oe)
    else $error("data out not driven while enabled");
  AST_WORD_LEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (eng_done && is_master && control_1_q[spc_pkg::WORD_WIDTH_SELECT_BIT]) |->
    fall_cnt_q == 5'd15)
    else $error("word transfer not 16 bits");
  AST_BYTE_LEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (eng_done && is_master && !control_1_q[spc_pkg::WORD_WIDTH_SELECT_BIT]) |->
    fall_cnt_q == 5'd7 && eng_rx[15:8] == 8'h00)
    else $error("byte transfer not 8 bits");
  AST_SEL_GATES: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!is_master && control_1_q[spc_pkg::SLAVE_SELECT_ENABLE_BIT] && sync2_q[2]) |=>
    !eng_done)
    else $error("deselected slave finished a transfer");
  AST_SEL_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !control_1_q[spc_pkg::SLAVE_SELECT_ENABLE_BIT] |-> sel_ok ##1 port_owns_select)
    else $error("select pin used while disabled");
  AST_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rvalid_q && $past(rd_fire) && $past(s_axi_araddr) == spc_pkg::ADDR_CONTROL_1) |->
    rdata_q[31:13] == 19'h00000)
    else $error("unimplemented control bits read nonzero");
  AST_WRITE_RESP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_fire |=> s_axi_bvalid ##0 control_1_q[15:13] == 3'h0)
    else $error("write response missing");

  COV_WORD: cover property (@(posedge ref_clk) disable iff (!rst_b)
    eng_done && control_1_q[spc_pkg::WORD_WIDTH_SELECT_BIT]);
  COV_BYTE: cover property (@(posedge ref_clk) disable iff (!rst_b)
    eng_done && !control_1_q[spc_pkg::WORD_WIDTH_SELECT_BIT]);
  COV_OVERFLOW: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(overflow_q));
endmodule : spc_top

/* testbench/spc_peer.sv */
`timescale 1ns/1ns
module spc_peer (
  input wire logic ref_clk,
  input wire logic clk_from_dut,
  input wire logic data_from_dut,
  output logic clk_to_dut,
  output logic data_to_dut,
  output logic sel_b
);
  logic [15:0] sreg = 16'h0000;
  logic [15:0] rx = 16'h0000;
  int cnt = 0;
  int nbits = 8;
  logic armed = 1'b0;
  logic junk = 1'b0;
  initial
  begin
    clk_to_dut = 1'b0;
    sel_b = 1'b1;
  end
  // A released line flips every cycle so a stale level never passes for data
  assign data_to_dut = armed ? sreg[15] : junk;
  always @(posedge ref_clk) junk <= ~junk;
  // Slave role: sample on the rising edge, shift on the falling edge
  always @(posedge clk_from_dut)
  begin
    rx <= {rx[14:0], data_from_dut};
    cnt <= cnt + 1;
  end
  always @(negedge clk_from_dut)
  begin
    sreg <= sreg << 1;
    if (cnt >= nbits) armed <= 1'b0;
  end
  task automatic arm(input int n, input logic [15:0] w);
    nbits <= n;
    sreg <= w << (16 - n);
    cnt <= 0;
    rx <= 16'h0000;
    armed <= 1'b1;
  endtask : arm
  // Master role: the clock stands low outside the frame; sel high drives sel_b low to select
  task automatic frame(input int n, input logic [15:0] w, input logic sel);
    arm(n, w);
    sel_b <= ~sel;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      clk_to_dut <= 1'b1;
      rx <= {rx[14:0], data_from_dut};
      repeat (8) @(posedge ref_clk);
      clk_to_dut <= 1'b0;
      sreg <= sreg << 1;
      repeat (8) @(posedge ref_clk);
    end
    sel_b <= 1'b1;
    armed <= 1'b0;
  endtask : frame
endmodule : spc_peer

/* testbench/spc_top_tb.sv */
`timescale 1ns/1ns
module spc_top_tb;
  typedef struct packed {
    logic [15:0] wr;
    logic [15:0] rd;
    logic oe;
    logic own;
    logic ck;
  } spc_row_t;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic pclk;
  logic pdata;
  logic psel_b;
  logic sdo;
  logic sdo_oe;
  logic sck;
  logic sck_oe;
  logic own;
  logic sdo_wire;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  // Pull-up on the data-out net while the block lets go of it
  assign sdo_wire = sdo_oe ? sdo : 1'b1;
  // Rows other than the all-ones last row keep clock-edge and sample-phase zero; the first two set both prescale fields to 1
  spc_row_t rows [5] = '{
    '{16'h0825, 16'h0825, 1'b0, 1'b1, 1'b1},
    '{16'h0025, 16'h0025, 1'b1, 1'b1, 1'b1},
    '{16'h0080, 16'h0080, 1'b1, 1'b0, 1'b0},
    '{16'he000, 16'h0000, 1'b1, 1'b1, 1'b0},
    '{16'hffff, 16'h1fff, 1'b0, 1'b0, 1'b0}};
  always #5 ref_clk = ~ref_clk;
  spc_top u_spc_top (
    .ref_clk(ref_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_data_in_pin(pdata), .serial_clock_in_pin(pclk), .slave_select_pin(psel_b),
    .serial_data_out_pin(sdo), .serial_data_out_oe(sdo_oe),
    .serial_clock_out_pin(sck), .serial_clock_out_oe(sck_oe), .port_owns_select(own));
  spc_peer u_spc_peer (
    .ref_clk(ref_clk), .clk_from_dut(sck), .data_from_dut(sdo_wire),
    .clk_to_dut(pclk), .data_to_dut(pdata), .sel_b(psel_b));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] v, output logic [1:0] r);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
    bready <= 1'b1;
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic wait_rx();
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 300; k++)
    begin
      rd(spc_pkg::ADDR_STATUS, d, r);
      if (d[spc_pkg::STAT_RX_FULL_BIT] === 1'b1) break;
    end
  endtask : wait_rx
  // Master transfer: the peer counts clock edges, so width shows at the pins
  task automatic xfer_m(input logic [15:0] c, input int n, input logic [15:0] tx,
                        input logic [15:0] pw);
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] m;
    m = (n == 16) ? 16'hffff : 16'h00ff;
    wr(spc_pkg::ADDR_CONTROL_1, c, r);
    u_spc_peer.arm(n, pw);
    wr(spc_pkg::ADDR_DATA, tx, r);
    wait_rx();
    rd(spc_pkg::ADDR_DATA, d, r);
    check(d, {16'h0000, pw & m});
    check(u_spc_peer.rx & m, tx & m);
    check(32'(u_spc_peer.cnt), 32'(n));
  endtask : xfer_m
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count++;
      end_sim();
    end
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    wr(spc_pkg::ADDR_STATUS, 16'h0001, r);
    foreach (rows[i])
    begin
      wr(spc_pkg::ADDR_CONTROL_1, rows[i].wr, r);
      rd(spc_pkg::ADDR_CONTROL_1, d, r);
      check(d, {16'h0000, rows[i].rd});
      check(sdo_oe, rows[i].oe);
      check(own, rows[i].own);
      check(sck_oe, rows[i].ck);
    end
    xfer_m(16'h0025, 8, 16'h1234, 16'h00a5);
    xfer_m(16'h0425, 16, 16'h1234, 16'hc35a);
    // Slave with select honoured: a frame with select high must be ignored
    wr(spc_pkg::ADDR_CONTROL_1, 16'h0080, r);
    wr(spc_pkg::ADDR_DATA, 16'h00c6, r);
    u_spc_peer.frame(8, 16'h003c, 1'b0);
    rd(spc_pkg::ADDR_STATUS, d, r);
    check(d[spc_pkg::STAT_RX_FULL_BIT], 1'b0);
    check(own, 1'b0);
    u_spc_peer.frame(8, 16'h003c, 1'b1);
    wait_rx();
    rd(spc_pkg::ADDR_DATA, d, r);
    check(d, 32'h0000003c);
    check(u_spc_peer.rx[7:0], 8'hc6);
    // Select ignored: the same unselected frame now completes
    wr(spc_pkg::ADDR_CONTROL_1, 16'h0000, r);
    repeat (2) @(posedge ref_clk);
    check(own, 1'b1);
    wr(spc_pkg::ADDR_DATA, 16'h0081, r);
    u_spc_peer.frame(8, 16'h0042, 1'b0);
    wait_rx();
    rd(spc_pkg::ADDR_DATA, d, r);
    check(d, 32'h00000042);
    check(u_spc_peer.rx[7:0], 8'h81);
    // Two unread words: the second is dropped and the overflow flag set
    wr(spc_pkg::ADDR_DATA, 16'h0011, r);
    u_spc_peer.frame(8, 16'h0055, 1'b0);
    wr(spc_pkg::ADDR_DATA, 16'h0022, r);
    u_spc_peer.frame(8, 16'h0066, 1'b0);
    rd(spc_pkg::ADDR_STATUS, d, r);
    check(d, 32'h0000000d);
    wr(spc_pkg::ADDR_STATUS, 16'h0009, r);
    rd(spc_pkg::ADDR_DATA, d, r);
    check(d, 32'h00000055);
    rd(spc_pkg::ADDR_STATUS, d, r);
    check(d, 32'h00000001);
    wr(4'hc, 16'hffff, r);
    check(r, spc_pkg::RESP_SLVERR);
    rd(4'hc, d, r);
    check(r, spc_pkg::RESP_SLVERR);
    check(d, 32'h00000000);
    // Reset in mid-run must clear every control field
    wr(spc_pkg::ADDR_CONTROL_1, 16'h0ca5, r);
    rst_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check(sdo_oe, 1'b0);
    check(own, 1'b1);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(spc_pkg::ADDR_CONTROL_1, d, r);
    check(d, 32'h00000000);
    end_sim();
  end
endmodule : spc_top_tb
